// ### rxs_pkg.sv
// package: register map, field layout and codes for the rx sense block
package rxs_pkg;
  // apb geometry: printed offsets are word indices, byte addr = 4 * index
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned ADDR_LSB = 2;
  localparam logic [1:0] ADDR_ALIGN = 2'h0;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // register indices
  localparam logic [IDX_W-1:0] IDX_RX_SENSE_CFG_CH7_8 = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_RX_LEVEL_CH1_2 = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_RX_LEVEL_CH3_4 = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_RX_LEVEL_CH5_6 = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_RX_SENSE_CFG_CH15_16 = 6'h2b;
  localparam logic [IDX_W-1:0] IDX_RX_LEVEL_CH9_10 = 6'h2c;
  localparam logic [IDX_W-1:0] IDX_RX_LEVEL_CH11_12 = 6'h2d;

  // reset values
  localparam logic [REG_W-1:0] CFG_RST = 8'h00;
  localparam logic [REG_W-1:0] LEVEL_RST = 8'h00;

  // config byte layout: even channel high nibble, odd channel low nibble
  localparam int unsigned EVEN_TR_BIT = 7;
  localparam int unsigned EVEN_SEL_LSB = 4;
  localparam int unsigned ODD_TR_BIT = 3;
  localparam int unsigned ODD_SEL_LSB = 0;
  localparam int unsigned SEL_W = 3;

  // level byte layout: higher channel bits 7:4, lower channel bits 3:0
  localparam int unsigned LVL_W = 4;
  localparam int unsigned LVL_HI_LSB = 4;
  localparam int unsigned LVL_LO_LSB = 0;
  localparam logic [LVL_W-1:0] LVL_RST = 4'h0;

  // sensitivity / monitor select codes
  localparam logic [SEL_W-1:0] SEL_SENS_12DB = 3'h0;
  localparam logic [SEL_W-1:0] SEL_SENS_18DB = 3'h1;
  localparam logic [SEL_W-1:0] SEL_MON_14DB = 3'h4;
  localparam logic [SEL_W-1:0] SEL_MON_20DB = 3'h5;

  // register and channel counts
  localparam int unsigned N_CFG_REG = 2;
  localparam int unsigned N_CFG_CH = 4;
  localparam int unsigned N_LVL_REG = 5;
  localparam int unsigned N_LVL_CH = 10;
endpackage : rxs_pkg

// ### rxs_cfg_if.sv
// interface: one channel's raw config fields and decoded receiver controls
`timescale 1ns/10ps
interface rxs_cfg_if;
  logic turns_ratio;
  logic [rxs_pkg::SEL_W-1:0] sens_sel;
  logic ratio_1to1;
  logic monitor_en;
  logic sens_18db;
  logic gain_20db;
  logic sel_undef;

  modport cfg (
    output turns_ratio,
    output sens_sel,
    input ratio_1to1,
    input monitor_en,
    input sens_18db,
    input gain_20db,
    input sel_undef
  );

  modport dec (
    input turns_ratio,
    input sens_sel,
    output ratio_1to1,
    output monitor_en,
    output sens_18db,
    output gain_20db,
    output sel_undef
  );
endinterface : rxs_cfg_if

// ### rxs_chan_dec.sv
// module: registered decode of one channel's turns ratio and select code
`timescale 1ns/10ps
module rxs_chan_dec (
  input wire logic pclk,
  input wire logic presetn,
  rxs_cfg_if.dec ch
);
  logic ratio_1to1;
  logic monitor_en;
  logic sens_18db;
  logic gain_20db;
  logic sel_undef;
  logic next_ratio_1to1;
  logic next_monitor_en;
  logic next_sens_18db;
  logic next_gain_20db;
  logic next_sel_undef;

  // decode select; undefined codes fall back to the 12 db setting
  always_comb
  begin
    next_ratio_1to1 = ch.turns_ratio;
    next_monitor_en = 1'b0;
    next_sens_18db = 1'b0;
    next_gain_20db = 1'b0;
    next_sel_undef = 1'b0;
    case (ch.sens_sel)
      rxs_pkg::SEL_SENS_12DB: next_sens_18db = 1'b0;
      rxs_pkg::SEL_SENS_18DB: next_sens_18db = 1'b1;
      rxs_pkg::SEL_MON_14DB: next_monitor_en = 1'b1;
      rxs_pkg::SEL_MON_20DB:
      begin
        next_monitor_en = 1'b1;
        next_gain_20db = 1'b1;
      end
      default: next_sel_undef = 1'b1;
    endcase
  end

  // register the controls so the analog side sees glitch-free levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ratio_1to1 <= 1'b0;
      monitor_en <= 1'b0;
      sens_18db <= 1'b0;
      gain_20db <= 1'b0;
      sel_undef <= 1'b0;
    end
    else
    begin
      ratio_1to1 <= next_ratio_1to1;
      monitor_en <= next_monitor_en;
      sens_18db <= next_sens_18db;
      gain_20db <= next_gain_20db;
      sel_undef <= next_sel_undef;
    end
  end

  assign ch.ratio_1to1 = ratio_1to1;
  assign ch.monitor_en = monitor_en;
  assign ch.sens_18db = sens_18db;
  assign ch.gain_20db = gain_20db;
  assign ch.sel_undef = sel_undef;
endmodule : rxs_chan_dec

// ### rxs_regs.sv
// module: apb register bank for receive sensitivity config and level status
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module rxs_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rxs_pkg::ADDR_W-1:0] paddr,
  input wire logic [rxs_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rxs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [rxs_pkg::N_LVL_CH-1:0][rxs_pkg::LVL_W-1:0] rx_level_code,
  output logic [rxs_pkg::N_CFG_CH-1:0] rx_ratio_1to1,
  output logic [rxs_pkg::N_CFG_CH-1:0] rx_monitor_en,
  output logic [rxs_pkg::N_CFG_CH-1:0] rx_sens_18db,
  output logic [rxs_pkg::N_CFG_CH-1:0] rx_gain_20db,
  output logic [rxs_pkg::N_CFG_CH-1:0] rx_sel_undef
);
  // config bytes: 0 serves channels 7/8, 1 serves channels 15/16
  logic [rxs_pkg::N_CFG_REG-1:0][rxs_pkg::REG_W-1:0] cfg;
  logic [rxs_pkg::N_CFG_REG-1:0][rxs_pkg::REG_W-1:0] next_cfg;
  logic [rxs_pkg::DATA_W-1:0] next_prdata;
  logic next_pslverr;

  // level codes: index 0..5 are channels 1..6, 6..9 are channels 9..12
  logic [rxs_pkg::N_LVL_CH-1:0][rxs_pkg::LVL_W-1:0] lvl_sync1;
  logic [rxs_pkg::N_LVL_CH-1:0][rxs_pkg::LVL_W-1:0] lvl_sync2;
  logic [rxs_pkg::N_LVL_CH-1:0][rxs_pkg::LVL_W-1:0] lvl_sync3;
  logic [rxs_pkg::N_LVL_CH-1:0][rxs_pkg::LVL_W-1:0] level;
  logic [rxs_pkg::N_LVL_CH-1:0][rxs_pkg::LVL_W-1:0] next_level;
  logic [rxs_pkg::N_LVL_REG-1:0][rxs_pkg::REG_W-1:0] lvl_byte;

  logic [rxs_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic setup;
  logic access;

  assign idx = paddr[rxs_pkg::ADDR_W-1:rxs_pkg::ADDR_LSB];
  assign aligned = (paddr[rxs_pkg::ADDR_LSB-1:0] == rxs_pkg::ADDR_ALIGN);
  assign setup = psel && !penable;
  assign access = psel && penable;

  // zero wait states: reply data is prepared in the setup cycle
  assign pready = 1'b1;

  // pair channels into status bytes, higher channel in the high nibble
  genvar g;
  generate
    for (g = 0; g < rxs_pkg::N_LVL_REG; g++)
    begin : g_lvl_byte
      assign lvl_byte[g] = {level[2*g+1], level[2*g]};
    end
  endgenerate

  // read decode acts on the setup cycle so the access phase only has to
  // present registered data; writes wait for the completing access edge
  always_comb
  begin
    next_cfg = cfg;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup)
    begin
      next_prdata = '0;
      next_pslverr = 1'b0;
      if (!aligned)
      begin
        next_pslverr = 1'b1;
      end
      else
      begin
        case (idx)
          rxs_pkg::IDX_RX_SENSE_CFG_CH7_8:
            next_prdata[rxs_pkg::REG_W-1:0] = cfg[0];
          rxs_pkg::IDX_RX_SENSE_CFG_CH15_16:
            next_prdata[rxs_pkg::REG_W-1:0] = cfg[1];
          // status bytes: a write completes but changes nothing
          rxs_pkg::IDX_RX_LEVEL_CH1_2:
            next_prdata[rxs_pkg::REG_W-1:0] = lvl_byte[0];
          rxs_pkg::IDX_RX_LEVEL_CH3_4:
            next_prdata[rxs_pkg::REG_W-1:0] = lvl_byte[1];
          rxs_pkg::IDX_RX_LEVEL_CH5_6:
            next_prdata[rxs_pkg::REG_W-1:0] = lvl_byte[2];
          rxs_pkg::IDX_RX_LEVEL_CH9_10:
            next_prdata[rxs_pkg::REG_W-1:0] = lvl_byte[3];
          rxs_pkg::IDX_RX_LEVEL_CH11_12:
            next_prdata[rxs_pkg::REG_W-1:0] = lvl_byte[4];
          default: next_pslverr = 1'b1;
        endcase
      end
      if (!pwrite)
      begin
        // a failing read returns zero rather than stale data
        next_prdata = next_pslverr ? '0 : next_prdata;
      end
      else
      begin
        next_prdata = '0;
      end
    end
    // a write lands only on the access edge that completes the transfer,
    // so a setup cycle alone never disturbs the receiver controls
    if (access && pready && pwrite && aligned && pstrb[0])
    begin
      if (idx == rxs_pkg::IDX_RX_SENSE_CFG_CH7_8)
      begin
        next_cfg[0] = pwdata[rxs_pkg::REG_W-1:0];
      end
      if (idx == rxs_pkg::IDX_RX_SENSE_CFG_CH15_16)
      begin
        next_cfg[1] = pwdata[rxs_pkg::REG_W-1:0];
      end
    end
  end

  // bus-side state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= {rxs_pkg::N_CFG_REG{rxs_pkg::CFG_RST}};
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // level capture: the measurement circuit is asynchronous to pclk, so
  // each code is synchronised, and a code is only taken once it has been
  // seen twice in a row; a multi-bit change that skews across the two
  // flops therefore never lands in the status byte as a false band
  always_comb
  begin
    next_level = level;
    for (int i = 0; i < rxs_pkg::N_LVL_CH; i++)
    begin
      if (lvl_sync2[i] == lvl_sync3[i])
      begin
        next_level[i] = lvl_sync2[i];
      end
    end
  end

  // level synchronisers and status registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_sync1 <= {rxs_pkg::N_LVL_CH{rxs_pkg::LVL_RST}};
      lvl_sync2 <= {rxs_pkg::N_LVL_CH{rxs_pkg::LVL_RST}};
      lvl_sync3 <= {rxs_pkg::N_LVL_CH{rxs_pkg::LVL_RST}};
      level <= {rxs_pkg::N_LVL_CH{rxs_pkg::LVL_RST}};
    end
    else
    begin
      lvl_sync1 <= rx_level_code;
      lvl_sync2 <= lvl_sync1;
      lvl_sync3 <= lvl_sync2;
      level <= next_level;
    end
  end

  // per-channel decode: even channel from the high nibble, odd from the
  // low nibble; order of the outputs is ch7, ch8, ch15, ch16
  generate
    for (g = 0; g < rxs_pkg::N_CFG_CH; g++)
    begin : g_dec
      rxs_cfg_if ch_if ();

      if (g % 2 == 0)
      begin : g_odd
        assign ch_if.turns_ratio =
          cfg[g/2][rxs_pkg::ODD_TR_BIT];
        assign ch_if.sens_sel =
          cfg[g/2][rxs_pkg::ODD_SEL_LSB +: rxs_pkg::SEL_W];
      end
      else
      begin : g_even
        assign ch_if.turns_ratio =
          cfg[g/2][rxs_pkg::EVEN_TR_BIT];
        assign ch_if.sens_sel =
          cfg[g/2][rxs_pkg::EVEN_SEL_LSB +: rxs_pkg::SEL_W];
      end

      rxs_chan_dec u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .ch(ch_if.dec)
      );

      // decoded controls leave the block straight from the decoder flops
      assign rx_ratio_1to1[g] = ch_if.ratio_1to1;
      assign rx_monitor_en[g] = ch_if.monitor_en;
      assign rx_sens_18db[g] = ch_if.sens_18db;
      assign rx_gain_20db[g] = ch_if.gain_20db;
      assign rx_sel_undef[g] = ch_if.sel_undef;
    end
  endgenerate
endmodule : rxs_regs

// ### rxs_regs_checker.sv
// checker: bus and decode assertions for the rx sense register bank
`timescale 1ns/10ps
module rxs_regs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [9:0][3:0] rx_level_code,
  input wire logic [3:0] rx_ratio_1to1,
  input wire logic [3:0] rx_monitor_en,
  input wire logic [3:0] rx_sens_18db,
  input wire logic [3:0] rx_gain_20db,
  input wire logic [3:0] rx_sel_undef
);
  logic [39:0] lvl_prev;
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  logic setup;
  logic wr_lo;
  logic wr_hi;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // setup phases of interest; decode lags the setup edge by three samples
  assign setup = psel && !penable;
  assign wr_lo = setup && pwrite && paddr == 8'h2c && pstrb[0];
  assign wr_hi = setup && pwrite && paddr == 8'hac && pstrb[0];

  // level inputs are filtered, so only judge reads after a quiet spell
  always_comb
  begin
    next_quiet = quiet;
    if (rx_level_code != lvl_prev)
      next_quiet = 4'h0;
    else if (quiet != 4'hf)
      next_quiet = quiet + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet <= 4'h0;
      lvl_prev <= 40'h0;
    end
    else
    begin
      quiet <= next_quiet;
      lvl_prev <= rx_level_code;
    end
  end

  a_ratio_map: assert property (wr_lo |-> ##3
    rx_ratio_1to1[1:0] == {$past(pwdata[7], 3), $past(pwdata[3], 3)})
    else $error("turns ratio decode wrong");
  a_sens_sel: assert property (wr_lo |-> ##3
    rx_sens_18db[0] == ($past(pwdata[2:0], 3) == 3'h1))
    else $error("sensitivity decode wrong");
  a_mon_sel: assert property (wr_lo |-> ##3
    rx_monitor_en[1] == ($past(pwdata[6:5], 3) == 2'h2))
    else $error("monitor decode wrong");
  a_gain_sel: assert property (wr_hi |-> ##3
    rx_gain_20db[3] == ($past(pwdata[6:4], 3) == 3'h5))
    else $error("gain decode wrong");
  a_flat_excl: assert property (
    (rx_monitor_en & rx_sens_18db) == 4'h0)
    else $error("monitor and sensitivity both set");
  a_level_read: assert property (
    setup && !pwrite && paddr == 8'h30 && quiet == 4'hf |=>
    prdata == {24'h0, $past(rx_level_code[1]), $past(rx_level_code[0])})
    else $error("level byte read wrong");
  a_level_wr_ok: assert property (
    setup && pwrite && paddr == 8'h30 |=> !pslverr && pready)
    else $error("level write refused");
  a_reset_clear: assert property (
    $rose(presetn) |-> rx_ratio_1to1 == 4'h0 && prdata == 32'h0)
    else $error("outputs not clear after reset");
endmodule : rxs_regs_checker

bind rxs_regs rxs_regs_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .rx_level_code, .rx_ratio_1to1, .rx_monitor_en, .rx_sens_18db,
  .rx_gain_20db, .rx_sel_undef);

// ### rxs_tb.sv
// testbench: apb register tests for the rx sense register bank
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", nm, ex, got); \
  end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0][3:0] rx_level_code = '0;
  logic [3:0] rx_ratio_1to1, rx_monitor_en, rx_sens_18db;
  logic [3:0] rx_gain_20db, rx_sel_undef;
  int bad_count = 0;
  int compares = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] b;
  logic [2:0] ev, od;
  logic [7:0] lvl_addr [5] = '{8'h30, 8'h34, 8'h38, 8'hb0, 8'hb4};
  // software writes only the defined select codes
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h5};

  // 100 mhz clock
  always #5 pclk = ~pclk;

  rxs_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_level_code,
    .rx_ratio_1to1, .rx_monitor_en, .rx_sens_18db, .rx_gain_20db,
    .rx_sel_undef);

  task automatic final_report;
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // one apb transfer, held until pready is seen; idle edge after release
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no local wait limit: the watchdog ends a transfer that hangs
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    xfer(1'b0, a, 32'h0, 4'hf);
    `CHK("prdata", {24'h0, ex}, rd)
    `CHK("pslverr", 1'b0, er)
  endtask : rd_chk

  // hang guard, far beyond the roughly 160 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    final_report();
  end

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (lvl_addr[i]) rd_chk(lvl_addr[i], 8'h00);
    rd_chk(8'h2c, 8'h00);
    rd_chk(8'hac, 8'h00);
    // every defined select code on both halves, turns bits toggled
    for (int i = 0; i < 4; i++)
    begin
      ev = codes[i];
      od = codes[3-i];
      b = {i[0], ev, ~i[0], od};
      xfer(1'b1, 8'h2c, {24'h0, b}, 4'h1);
      xfer(1'b1, 8'hac, {24'h0, b}, 4'h1);
      repeat (2) @(posedge pclk);
      `CHK("ratio", {2{b[7], b[3]}}, rx_ratio_1to1)
      `CHK("mon", {2{ev[2], od[2]}}, rx_monitor_en)
      `CHK("s18", {2{ev == 3'h1, od == 3'h1}}, rx_sens_18db)
      `CHK("g20", {2{ev == 3'h5, od == 3'h5}}, rx_gain_20db)
      `CHK("undef", 4'h0, rx_sel_undef)
      rd_chk(8'h2c, b);
      rd_chk(8'hac, b);
    end
    // byte strobe off: config must not move
    xfer(1'b1, 8'h2c, 32'hff, 4'h0);
    rd_chk(8'h2c, b);
    // level codes 7 down to 0 then 7, 6 across the channels, settled past the input filter
    for (int i = 0; i < 10; i++)
    begin
      rx_level_code[i] <= 4'(7 - i % 8);
    end
    repeat (20) @(posedge pclk);
    foreach (lvl_addr[r])
    begin
      b = {rx_level_code[2*r+1], rx_level_code[2*r]};
      rd_chk(lvl_addr[r], b);
    end
    xfer(1'b1, 8'h30, 32'hff, 4'hf);
    `CHK("lvl wr err", 1'b0, er)
    rd_chk(8'h30, 8'h67);
    // unmapped index is refused with an error and zero data
    xfer(1'b0, 8'h3c, 32'h0, 4'hf);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    // unaligned read is refused too, and an unaligned write changes nothing
    xfer(1'b0, 8'h2d, 32'h0, 4'hf);
    `CHK("unaligned err", 1'b1, er)
    `CHK("unaligned data", 32'h0, rd)
    xfer(1'b1, 8'h2d, 32'h5a, 4'h1);
    `CHK("unaligned wr err", 1'b1, er)
    rd_chk(8'h2c, {1'b1, 3'h5, 1'b0, 3'h0});
    // reset in mid-run clears config and decode
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK("ratio rst", 4'h0, rx_ratio_1to1)
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(8'hac, 8'h00);
    rd_chk(8'h2c, 8'h00);
    final_report();
  end
endmodule : testbench
